// [hdl/rcd_defines.svh]
// constants for the register access command decoder
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

// apb byte addresses of the software-visible words
`define RCD_CMD_ADDR 12'h000
`define RCD_DEC_ADDR 12'h004
`define RCD_DATA_ADDR 12'h008
`define RCD_RDATA_ADDR 12'h00C

// command byte fields
`define RCD_GATE_BIT 7
`define RCD_DIR_BIT 6
`define RCD_SEL_HI 5
`define RCD_SEL_LO 0

// reset values
`define RCD_CMD_RESET 8'h00
`define RCD_WORD_RESET 32'h00000000

// target select codes and group bases
`define RCD_SEL_STATUS 6'h00
`define RCD_SEL_ADCMODE 6'h01
`define RCD_SEL_IFMODE 6'h02
`define RCD_SEL_CHECKSUM 6'h03
`define RCD_SEL_DATA 6'h04
`define RCD_SEL_GPIO 6'h06
`define RCD_SEL_ID 6'h07
`define RCD_GRP_CHAN 2'h1
`define RCD_GRP_SETUP 3'h4
`define RCD_GRP_FILT 3'h5
`define RCD_GRP_OFFS 3'h6
`define RCD_GRP_GAIN 3'h7

`endif

// [hdl/rcd_pkg.sv]
// types shared by the register access command decoder
package rcd_pkg;

    typedef enum logic [3:0] {
        rcd_t_none,
        rcd_t_status,
        rcd_t_adc_mode,
        rcd_t_if_mode,
        rcd_t_checksum,
        rcd_t_data,
        rcd_t_gpio,
        rcd_t_id,
        rcd_t_channel,
        rcd_t_setup,
        rcd_t_filter,
        rcd_t_offset,
        rcd_t_gain
    } rcd_target_e;

    typedef struct packed {
        logic valid;
        logic read;
        logic [5:0] target_select;
        rcd_target_e target;
        logic [3:0] index;
    } rcd_decode_s;

    typedef enum logic [1:0] {
        rcd_idle,
        rcd_armed
    } rcd_state_e;

endpackage

// [hdl/rcd_decoder.sv]
// command byte decoder with apb register port
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "rcd_defines.svh"

module rcd_decoder
    import rcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] target_rdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output rcd_decode_s phase,
    output logic target_wr,
    output logic target_rd,
    output logic [31:0] target_wdata
);

    // sequencer state, live decode, raw command byte and read buffer
    rcd_state_e state;
    rcd_decode_s next_phase;
    logic [7:0] command_register;
    logic [31:0] read_word;
    logic setup;
    logic cmd_read;

    // map a target select onto a register group and index
    // unassigned codes fall through to none so nothing is struck
    function automatic rcd_decode_s decode(input logic [7:0] cmd);
        rcd_decode_s d;
        logic [5:0] s;
        s = cmd[`RCD_SEL_HI:`RCD_SEL_LO];
        d.valid = ~cmd[`RCD_GATE_BIT];
        d.read = cmd[`RCD_DIR_BIT];
        d.target_select = s;
        d.index = 4'h0;
        d.target = rcd_t_none;
        if (s[5:4] == `RCD_GRP_CHAN) begin
            d.target = rcd_t_channel;
            d.index = s[3:0];
        end else if (s[5:3] == `RCD_GRP_SETUP) begin
            d.target = rcd_t_setup;
            d.index = {1'b0, s[2:0]};
        end else if (s[5:3] == `RCD_GRP_FILT) begin
            d.target = rcd_t_filter;
            d.index = {1'b0, s[2:0]};
        end else if (s[5:3] == `RCD_GRP_OFFS) begin
            d.target = rcd_t_offset;
            d.index = {1'b0, s[2:0]};
        end else if (s[5:3] == `RCD_GRP_GAIN) begin
            d.target = rcd_t_gain;
            d.index = {1'b0, s[2:0]};
        end else begin
            case (s)
                `RCD_SEL_STATUS: d.target = rcd_t_status;
                `RCD_SEL_ADCMODE: d.target = rcd_t_adc_mode;
                `RCD_SEL_IFMODE: d.target = rcd_t_if_mode;
                `RCD_SEL_CHECKSUM: d.target = rcd_t_checksum;
                `RCD_SEL_DATA: d.target = rcd_t_data;
                `RCD_SEL_GPIO: d.target = rcd_t_gpio;
                `RCD_SEL_ID: d.target = rcd_t_id;
                default: d.target = rcd_t_none;
            endcase
        end
        return d;
    endfunction

    // setup qualifier, live decode and stored direction; every action
    // happens in setup so a stretched access never repeats it
    assign setup = psel & ~penable;
    assign next_phase = decode(pwdata[7:0]);
    assign cmd_read = command_register[`RCD_DIR_BIT];

    // apb answers in the access cycle; pready pulses for zero-wait access
    // no wait states are inserted, so the master sees one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // unmapped addresses and out-of-order data phases flag an error
    // a wrong-direction data access is refused and leaves the command armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            case (paddr)
                `RCD_CMD_ADDR: pslverr <= ~pwrite;
                `RCD_DEC_ADDR: pslverr <= pwrite;
                `RCD_DATA_ADDR: pslverr <= (state != rcd_armed) |
                    (pwrite == cmd_read);
                `RCD_RDATA_ADDR: pslverr <= pwrite;
                default: pslverr <= 1'b1;
            endcase
        end else begin
            pslverr <= 1'b0;
        end
    end

    // command byte store, write only; gated bytes are ignored
    // it is the reference for the direction of the pending data phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_register <= `RCD_CMD_RESET;
        end else if (setup && pwrite && paddr == `RCD_CMD_ADDR &&
                     !pwdata[`RCD_GATE_BIT]) begin
            command_register <= pwdata[7:0];
        end
    end

    // decoded phase is held for exactly one data phase
    // a new valid command simply overwrites one still pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= '0;
        end else if (setup && pwrite && paddr == `RCD_CMD_ADDR) begin
            if (next_phase.valid) begin
                phase <= next_phase;
            end
        end else if (setup && paddr == `RCD_DATA_ADDR &&
                     state == rcd_armed && pwrite != phase.read) begin
            phase.valid <= 1'b0;
        end
    end

    // sequencer: only an accepted command arms a data phase
    // only a data access in the commanded direction closes the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rcd_idle;
        end else begin
            case (state)
                rcd_idle: begin
                    if (setup && pwrite && paddr == `RCD_CMD_ADDR &&
                        next_phase.valid) begin
                        state <= rcd_armed;
                    end
                end
                rcd_armed: begin
                    if (setup && paddr == `RCD_DATA_ADDR &&
                        pwrite != cmd_read) begin
                        state <= rcd_idle;
                    end
                end
                default: state <= rcd_idle;
            endcase
        end
    end

    // strobes to the register bank; unassigned targets are never struck
    // the bank must answer a read while target_rd stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_wr <= 1'b0;
            target_rd <= 1'b0;
            target_wdata <= `RCD_WORD_RESET;
        end else begin
            target_wr <= 1'b0;
            target_rd <= 1'b0;
            if (setup && paddr == `RCD_DATA_ADDR && state == rcd_armed &&
                phase.target != rcd_t_none) begin
                target_wr <= pwrite & ~cmd_read;
                target_rd <= ~pwrite & cmd_read;
                if (pwrite && !cmd_read) begin
                    target_wdata <= pwdata;
                end
            end
        end
    end

    // latched read data for the data phase; zero for unassigned codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_word <= `RCD_WORD_RESET;
        end else if (target_rd) begin
            read_word <= target_rdata;
        end else if (setup && paddr == `RCD_DATA_ADDR &&
                     state == rcd_armed && !pwrite &&
                     phase.target == rcd_t_none) begin
            read_word <= `RCD_WORD_RESET;
        end
    end

    // read mux; command word reads as zero since it is write only
    // status word: armed 19, valid 18, read 17, target 16:13, index 12:9
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RCD_WORD_RESET;
        end else if (setup && !pwrite) begin
            case (paddr)
                `RCD_DEC_ADDR: prdata <= {12'h000, state == rcd_armed,
                    phase.valid, phase.read, phase.target,
                    phase.index, 3'h0, phase.target_select};
                `RCD_RDATA_ADDR: prdata <= read_word;
                default: prdata <= `RCD_WORD_RESET;
            endcase
        end else begin
            prdata <= `RCD_WORD_RESET;
        end
    end

endmodule

// [test/rcd_decoder_props.sv]
// port assertions for the command decoder
`timescale 1ns/1ps
module rcd_decoder_props
    import rcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire rcd_decode_s phase,
    input wire logic target_wr,
    input wire logic target_rd,
    input wire logic [31:0] target_wdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup cycle and command write qualifiers
    wire setup = psel && !penable;
    wire cmd_w = setup && pwrite && paddr == 12'h000;
    wire [5:0] ts = phase.target_select;
    chk_answer_next: assert property (setup |=> pready)
        else $error("no answer after setup");
    chk_cmd_unread: assert property (
        setup && !pwrite && paddr == 12'h000 |=> pslverr && prdata == 32'h0)
        else $error("command word readable");
    chk_gate_ignored: assert property (
        cmd_w && pwdata[7] |=> $stable(phase))
        else $error("gated command changed decode");
    chk_cmd_fields: assert property (
        cmd_w && !pwdata[7] |=> phase.valid
        && phase.read == $past(pwdata[6]) && ts == $past(pwdata[5:0]))
        else $error("command fields not captured");
    chk_chan_map: assert property (
        phase.valid && ts[5:4] == 2'h1
        |-> phase.target == rcd_t_channel && phase.index == ts[3:0])
        else $error("channel decode wrong");
    chk_setup_map: assert property (
        phase.valid && ts[5:3] == 3'h4 |-> phase.target == rcd_t_setup)
        else $error("setup decode wrong");
    chk_gain_map: assert property (
        phase.valid && ts[5:3] == 3'h7
        |-> phase.target == rcd_t_gain && phase.index == {1'b0, ts[2:0]})
        else $error("gain decode wrong");
    chk_hole_none: assert property (
        phase.valid && ts inside {6'h05, [6'h08:6'h0F]}
        |-> phase.target == rcd_t_none)
        else $error("unassigned code decoded");
    chk_strobe_ok: assert property (
        target_wr || target_rd |-> pready && !pslverr)
        else $error("strobe without clean answer");
    chk_wr_data: assert property (
        target_wr |-> pwrite && target_wdata == pwdata)
        else $error("write word not passed on");
    cover property (target_wr);
    cover property (target_rd);
    cover property (cmd_w && pwdata[7]);
endmodule

// [test/rcd_bank_model.sv]
// register bank stand-in behind the decoder strobes
`timescale 1ns/1ps
module rcd_bank_model (
    input wire logic pclk,
    input wire logic target_wr,
    input wire logic target_rd,
    input wire logic [31:0] target_wdata,
    output logic [31:0] target_rdata
);
    logic [31:0] word = 32'h0;
    // stores a write at the edge where the strobe is seen
    always @(posedge pclk) begin
        if (target_wr) begin
            word <= target_wdata;
        end
    end
    // answers while target_rd stands; shows the inverse when not asked
    // so stale data never passes for an answer
    assign target_rdata = target_rd ? word : ~word;
endmodule

// [test/rcd_decoder_tb_top.sv]
// self-checking bench for the command decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", n, e, g); mismatches++; end end
module rcd_decoder_tb_top
    import rcd_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, target_rdata, target_wdata, r;
    logic pready, pslverr, target_wr, target_rd, e, ws, rs;
    logic [7:0] x;
    rcd_decode_s phase;
    int mismatches = 0, samples_checked = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    rcd_decoder u_rcd_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .target_rdata(target_rdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase(phase), .target_wr(target_wr),
        .target_rd(target_rd), .target_wdata(target_wdata));
    rcd_bank_model u_rcd_bank_model (.pclk(pclk), .target_wr(target_wr),
        .target_rd(target_rd), .target_wdata(target_wdata),
        .target_rdata(target_rdata));
    // one apb transfer, then an idle cycle so strobes never merge
    task automatic xf(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        ws = target_wr;
        rs = target_rd;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // expected {target, index} for a select code
    function automatic logic [7:0] ex(input logic [5:0] c);
        if (c[5:4] == 2'h1) return {4'h8, c[3:0]};
        if (c[5]) return {4'(c[5:3]) + 4'h5, 1'b0, c[2:0]};
        if (c < 6'h05) return {4'(c) + 4'h1, 4'h0};
        if (c == 6'h06 || c == 6'h07) return {4'(c), 4'h0};
        return 8'h00;
    endfunction
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            print_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        xf(0, 12'h004, 0);
        `CHK("status", 32'h0, r)
        xf(0, 12'h000, 0);
        `CHK("cmd_rd", 33'h100000000, {e, r})
        $display("test reset done");
        for (int c = 0; c < 64; c++) begin
            xf(1, 12'h000, {24'h0, 1'b0, c[0], 6'(c)});
            xf(0, 12'h004, 0);
            x = ex(6'(c));
            `CHK("decode", {12'h000, 2'h3, c[0], x, 3'h0, 6'(c)}, r)
            `CHK("phase", {1'b1, c[0], 6'(c), x}, phase)
        end
        $display("test decode done");
        xf(1, 12'h000, 32'hC1);
        xf(0, 12'h004, 0);
        `CHK("gated", 7'h7F, {r[17], r[5:0]})
        xf(1, 12'h000, 32'h13);
        xf(1, 12'h008, 32'hA5C31E7F);
        `CHK("wr", 34'h1A5C31E7F, {e, ws, target_wdata})
        xf(1, 12'h008, 32'h0);
        `CHK("wr_again", 2'h2, {e, ws})
        xf(1, 12'h000, 32'h53);
        xf(0, 12'h008, 0);
        `CHK("rd", 2'h1, {e, rs})
        xf(0, 12'h00C, 0);
        `CHK("rd_word", 32'hA5C31E7F, r)
        xf(1, 12'h000, 32'h53);
        xf(1, 12'h008, 32'h0);
        `CHK("dir", 2'h2, {e, ws})
        xf(1, 12'h000, 32'h45);
        xf(0, 12'h008, 0);
        `CHK("hole_rd", 2'h0, {e, rs})
        xf(0, 12'h00C, 0);
        `CHK("hole_word", 32'h0, r)
        xf(1, 12'h000, 32'h05);
        xf(1, 12'h008, 32'h1);
        `CHK("hole_wr", 34'h0A5C31E7F, {e, ws, target_wdata})
        xf(0, 12'h010, 0);
        `CHK("unmapped", 1'b1, e)
        xf(1, 12'h00C, 0);
        `CHK("rdata_wr", 1'b1, e)
        $display("test transfers done");
        print_verdict;
    end
endmodule
bind rcd_decoder rcd_decoder_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase(phase), .target_wr(target_wr), .target_rd(target_rd),
    .target_wdata(target_wdata));
